/* dv/ldo_channel_control_tb.sv */
// Testbench for the LDO channel control block
`timescale 1ns/1ps
`default_nettype none
module ldo_channel_control_tb;
  logic clk = 0, rst_n = 0, irq_out_n, slow = 0;
  logic [3:0] level_wr = 0, enable = 0, output_discharge_enable = 0, low_quiescent_select = 0;
  logic [3:0] fault_irq_enable = 0, uv_low = 0, pgood_rd, regulator_on, discharge_on, low_iq_on;
  logic [3:0] power_good, fault_pending;
  logic [5:0] level_wdata = 0;
  logic [11:0] turn_on_delay = 0;
  logic [23:0] output_level_code, exp = 0;
  int failures = 0, compares = 0, seed = 32'hd4d07402, cyc = 0, n;
  always #2.5 clk = ~clk;
  ldo_channel_control #(.CYC_PER_MS(10)) dut (
    .clk(clk), .rst_n(rst_n), .level_wr(level_wr), .level_wdata(level_wdata), .enable(enable),
    .turn_on_delay(turn_on_delay), .output_discharge_enable(output_discharge_enable),
    .low_quiescent_select(low_quiescent_select), .fault_irq_enable(fault_irq_enable), .pgood_rd(pgood_rd),
    .uv_low(uv_low), .output_level_code(output_level_code), .regulator_on(regulator_on),
    .discharge_on(discharge_on), .low_iq_on(low_iq_on), .power_good(power_good),
    .fault_pending(fault_pending), .irq_out_n(irq_out_n)
  );
  ldo_host host (.clk, .rst_n, .irq_out_n, .slow, .fault_pending, .pgood_rd);
  task chk(string s, logic [31:0] v, e);
    compares++;
    if (v !== e) begin
      failures++;
      $display("wrong value %s exp %0h seen %0h", s, e, v);
    end
  endtask
  function automatic int ms_of(int k);
    return k ? 2 << (k - 1) : 0;
  endfunction
  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    chk("lvl", output_level_code, 24'h0);
    rst_n <= 1;
    for (int i = 0; i < 5; i++) @(posedge clk) begin
      if (i > 0) exp[6*(i-1)+:6] = level_wdata;
      level_wr <= i < 4 ? 4'h1 << i : 4'h0;
      level_wdata <= i == 3 ? 6'h3F : 6'($random(seed));
    end
    @(posedge clk);
    @(negedge clk) chk("lvl", output_level_code, exp);
    $display("test level done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) begin
        turn_on_delay <= 12'(k);
        output_discharge_enable <= 4'($random(seed));
        low_quiescent_select <= 4'($random(seed));
        enable <= 4'h1;
      end
      n = 0;
      while (!regulator_on[0] && n < 1500) @(negedge clk) n++;
      chk("delay", k ? n >= (ms_of(k) - 1) * 10 + 3 && n <= ms_of(k) * 10 + 2 : n == 2, 1);
      chk("dis", discharge_on, output_discharge_enable & 4'hE);
      chk("liq", low_iq_on, low_quiescent_select);
      @(posedge clk) enable <= 4'h0;
      repeat (3) @(negedge clk);
      chk("off", regulator_on, 4'h0);
      chk("dis", discharge_on, output_discharge_enable);
    end
    $display("test enable done");
    @(posedge clk) begin
      fault_irq_enable <= 4'h1;
      uv_low <= 4'h3;
    end
    repeat (12) @(negedge clk);
    chk("pg", power_good, 4'hC);
    chk("fault", fault_pending, 4'h1);
    chk("irq", irq_out_n, 0);
    @(posedge clk) begin
      uv_low <= 4'h0;
      slow <= 1;
    end
    repeat (20) @(negedge clk);
    chk("irq", irq_out_n, 1);
    chk("pg", power_good, 4'hF);
    $display("test fault done");
    conclude();
  end
endmodule
bind ldo_channel_control ldo_chk #(.NUM_CH(NUM_CH)) chk_i (
  .clk(clk), .rst_n(rst_n), .irq_out_n(irq_out_n), .level_wr(level_wr), .enable(enable),
  .output_discharge_enable(output_discharge_enable), .low_quiescent_select(low_quiescent_select),
  .fault_irq_enable(fault_irq_enable), .pgood_rd(pgood_rd), .uv_low(uv_low), .regulator_on(regulator_on),
  .discharge_on(discharge_on), .low_iq_on(low_iq_on), .power_good(power_good), .fault_pending(fault_pending),
  .level_wdata(level_wdata), .turn_on_delay(turn_on_delay), .output_level_code(output_level_code)
);
`default_nettype wire

/* dv/ldo_chk.sv */
// Assertions for the LDO channel control block
`timescale 1ns/1ps
`default_nettype none
`include "ldo_cfg.svh"
module ldo_chk #(parameter int unsigned NUM_CH = 4) (
  input wire logic clk, rst_n, irq_out_n,
  input wire logic [NUM_CH-1:0] level_wr, enable, output_discharge_enable, low_quiescent_select,
  input wire logic [NUM_CH-1:0] fault_irq_enable, pgood_rd, uv_low, regulator_on, discharge_on,
  input wire logic [NUM_CH-1:0] low_iq_on, power_good, fault_pending,
  input wire logic [`LDO_LEVEL_W-1:0] level_wdata,
  input wire logic [NUM_CH*`LDO_DELAY_W-1:0] turn_on_delay,
  input wire logic [NUM_CH*`LDO_LEVEL_W-1:0] output_level_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet_read;
    !uv_low[0] [*5] ##0 pgood_rd[0];
  endsequence
  AST_LVL: assert property (level_wr[0] |=> output_level_code[5:0] == $past(level_wdata))
    else $error("level");
  AST_DIS: assert property (##1 discharge_on == $past(output_discharge_enable & ~enable))
    else $error("discharge");
  AST_LIQ: assert property (##1 low_iq_on == $past(low_quiescent_select))
    else $error("low iq");
  AST_PG: assert property (uv_low[0] [*4] |-> !power_good[0])
    else $error("power good");
  AST_IRQ: assert property ((fault_irq_enable[0] && uv_low[0]) [*4] |-> !irq_out_n)
    else $error("irq");
  AST_CLR: assert property (s_quiet_read |=> !fault_pending[0])
    else $error("clear");
  AST_ON: assert property ($rose(enable[0]) && turn_on_delay[2:0] == 3'h0 |-> ##1 regulator_on[0])
    else $error("on");
  AST_OFF: assert property (!enable[0] [*3] |-> !regulator_on[0])
    else $error("off");
endmodule
`default_nettype wire

/* dv/ldo_host.sv */
// Host model answering the fault interrupt
`timescale 1ns/1ps
`default_nettype none
module ldo_host (
  input wire logic clk, rst_n, irq_out_n, slow,
  input wire logic [3:0] fault_pending,
  output logic [3:0] pgood_rd
);
  logic [2:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      pgood_rd <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      // Slow host reads once every eight cycles
      pgood_rd <= (!irq_out_n && !(|pgood_rd) && (!slow || cnt_q == 3'h0)) ? fault_pending : 4'h0;
    end
  end
endmodule
`default_nettype wire

/* logic/ldo_cfg.svh */
// Constants for the LDO channel control block
`ifndef LDO_CFG_SVH
`define LDO_CFG_SVH
`define LDO_NUM_CH 4
`define LDO_LEVEL_W 6
`define LDO_DELAY_W 3
`define LDO_CLK_HZ 200000000
`define LDO_MS_UNIT 1
`define LDO_CYC_PER_MS ((`LDO_CLK_HZ / 1000) * `LDO_MS_UNIT)
`define LDO_DELAY_BASE_MS 2
`define LDO_DELAY_MAX_MS 128
`define LDO_DELAY_CNT_W 8
`define LDO_LEVEL_RST 6'h00
`endif

/* logic/ldo_channel_control.sv */
// Control for four LDO channels: level, enable, delay, discharge, low-iq, power-good irq
`include "ldo_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ldo_channel_control #(
  parameter int unsigned NUM_CH = `LDO_NUM_CH,
  parameter int unsigned CYC_PER_MS = `LDO_CYC_PER_MS,
  parameter logic [`LDO_LEVEL_W-1:0] LEVEL_DEFAULT = `LDO_LEVEL_RST
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host write of level codes, one strobe per channel
  input wire logic [NUM_CH-1:0] level_wr,
  input wire logic [`LDO_LEVEL_W-1:0] level_wdata,
  // Host-held configuration bits
  input wire logic [NUM_CH-1:0] enable,
  input wire logic [NUM_CH*`LDO_DELAY_W-1:0] turn_on_delay,
  input wire logic [NUM_CH-1:0] output_discharge_enable,
  input wire logic [NUM_CH-1:0] low_quiescent_select,
  input wire logic [NUM_CH-1:0] fault_irq_enable,
  // Host read strobe of power-good bits
  input wire logic [NUM_CH-1:0] pgood_rd,
  // Comparator inputs, asynchronous
  input wire logic [NUM_CH-1:0] uv_low,
  // Regulator controls
  output logic [NUM_CH*`LDO_LEVEL_W-1:0] output_level_code,
  output logic [NUM_CH-1:0] regulator_on,
  output logic [NUM_CH-1:0] discharge_on,
  output logic [NUM_CH-1:0] low_iq_on,
  // Status
  output logic [NUM_CH-1:0] power_good,
  output logic [NUM_CH-1:0] fault_pending,
  output logic irq_out_n
);
  import ldo_pkg::*;

  // Refuse settings the counters and tables cannot serve
  initial begin
    if (NUM_CH < 1 || NUM_CH > 8) begin
      $error("NUM_CH must be 1 to 8");
    end
    if (CYC_PER_MS < 1) begin
      $error("ms divider needs at least one cycle");
    end
    if (`LDO_LEVEL_W != 6) begin
      $error("level code must be six bits");
    end
    if (`LDO_DELAY_W != 3) begin
      $error("delay code must be three bits");
    end
    if (`LDO_MS_UNIT < 1) begin
      $error("ms unit must be at least one");
    end
    if (`LDO_DELAY_MAX_MS > (1 << `LDO_DELAY_CNT_W) - 1) begin
      $error("delay counter too narrow for the longest delay");
    end
    if ((`LDO_DELAY_BASE_MS << ((1 << `LDO_DELAY_W) - 2)) != `LDO_DELAY_MAX_MS) begin
      $error("delay table must double from base to maximum");
    end
  end

  typedef struct packed {
    // Comparator synchroniser, two stages
    logic [NUM_CH-1:0] uv_s1;
    logic [NUM_CH-1:0] uv_s2;
    // Programmed level codes
    logic [NUM_CH-1:0][`LDO_LEVEL_W-1:0] level;
    // Turn-on sequencer per channel
    logic [NUM_CH-1:0][2:0] st;
    logic [NUM_CH-1:0][`LDO_DELAY_CNT_W-1:0] ms_left;
    // Registered regulator controls
    logic [NUM_CH-1:0] reg_on;
    logic [NUM_CH-1:0] dis_on;
    logic [NUM_CH-1:0] liq_on;
    // Status and interrupt
    logic [NUM_CH-1:0] pg;
    logic [NUM_CH-1:0] flt;
    logic irq_n;
  } ldo_state_all_t;

  // Whole block state, registered in one place
  ldo_state_all_t s_q, s_d;
  logic ms_tick;
  logic [NUM_CH-1:0][`LDO_DELAY_W-1:0] delay_code;
  logic [NUM_CH-1:0] delay_zero;

  // Per-channel views of the packed delay bus
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign delay_code[g] = turn_on_delay[g*`LDO_DELAY_W +: `LDO_DELAY_W];
    assign delay_zero[g] = (delay_code[g] == `LDO_DELAY_W'(0));
  end

  // Free-running millisecond timebase shared by all channels
  ldo_ms_tick #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(ms_tick)
  );

  // Delay in ms: zero for code 0, otherwise the base doubled per step
  function automatic logic [`LDO_DELAY_CNT_W-1:0] delay_ms(input logic [`LDO_DELAY_W-1:0] code);
    logic [`LDO_DELAY_CNT_W-1:0] v;
    v = '0;
    if (code != `LDO_DELAY_W'(0)) begin
      v = `LDO_DELAY_CNT_W'(`LDO_DELAY_BASE_MS) << (code - `LDO_DELAY_W'(1));
    end
    return v;
  endfunction

  always_comb begin
    s_d = s_q;
    // Comparator outputs through two flops before use
    s_d.uv_s1 = uv_low;
    s_d.uv_s2 = s_q.uv_s1;

    // Level writes and turn-on sequencing
    for (int i = 0; i < NUM_CH; i++) begin
      // Level written by the host replaces the default
      if (level_wr[i]) begin
        s_d.level[i] = level_wdata;
      end
      case (s_q.st[i])
        LDO_OFF: begin
          if (enable[i]) begin
            s_d.ms_left[i] = delay_ms(delay_code[i]);
            // Zero delay turns on at once
            if (delay_zero[i]) begin
              s_d.st[i] = LDO_ON;
            end else begin
              s_d.st[i] = LDO_WAIT;
            end
          end
        end
        // Dropping enable while waiting aborts the turn-on
        LDO_WAIT: begin
          if (!enable[i]) begin
            s_d.ms_left[i] = '0;
            s_d.st[i] = LDO_OFF;
          end else if (ms_tick) begin
            if (s_q.ms_left[i] <= `LDO_DELAY_CNT_W'(1)) begin
              s_d.ms_left[i] = '0;
              s_d.st[i] = LDO_ON;
            end else begin
              s_d.ms_left[i] = s_q.ms_left[i] - `LDO_DELAY_CNT_W'(1);
            end
          end
        end
        // Clearing enable turns off; discharge may then act
        LDO_ON: begin
          if (!enable[i]) begin
            s_d.st[i] = LDO_OFF;
          end
        end
        default: begin
          s_d.st[i] = LDO_OFF;
        end
      endcase
    end

    // Regulator on follows the next state on the same edge; discharge and low-iq follow their inputs
    for (int i = 0; i < NUM_CH; i++) begin
      s_d.reg_on[i] = (s_d.st[i] == LDO_ON);
      s_d.dis_on[i] = output_discharge_enable[i] && !enable[i];
      s_d.liq_on[i] = low_quiescent_select[i];
    end

    // Status; a fault in the read cycle keeps its flag set
    for (int i = 0; i < NUM_CH; i++) begin
      s_d.pg[i] = !s_q.uv_s2[i];
      if (fault_irq_enable[i] && s_q.uv_s2[i]) begin
        s_d.flt[i] = 1'b1;
      end else if (pgood_rd[i]) begin
        s_d.flt[i] = 1'b0;
      end
    end
    // Interrupt low while any channel holds a fault
    s_d.irq_n = ~|s_d.flt;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.uv_s1 <= '0;
      s_q.uv_s2 <= '0;
      s_q.level <= {NUM_CH{LEVEL_DEFAULT}};
      s_q.st <= {NUM_CH{LDO_OFF}};
      s_q.ms_left <= '0;
      s_q.reg_on <= '0;
      s_q.dis_on <= '0;
      s_q.liq_on <= '0;
      s_q.pg <= '0;
      s_q.flt <= '0;
      s_q.irq_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output straight from a flop
  assign output_level_code = s_q.level;
  assign regulator_on = s_q.reg_on;
  assign discharge_on = s_q.dis_on;
  assign low_iq_on = s_q.liq_on;
  assign power_good = s_q.pg;
  assign fault_pending = s_q.flt;
  assign irq_out_n = s_q.irq_n;
endmodule
`default_nettype wire

/* logic/ldo_ms_tick.sv */
// Millisecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none
module ldo_ms_tick #(
  parameter int unsigned CYC_PER_MS = 200000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Tick
  output logic tick
);
  import ldo_pkg::*;

  initial begin
    if (CYC_PER_MS < 1) begin
      $error("CYC_PER_MS must be at least one");
    end
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ldo_tick_state_t;

  ldo_tick_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= CYC_PER_MS - 1) begin
      s_d.cnt = 32'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule
`default_nettype wire

/* logic/ldo_pkg.sv */
// Types for the LDO channel control block
package ldo_pkg;
  typedef enum logic [2:0] {
    LDO_OFF = 3'b001,
    LDO_WAIT = 3'b010,
    LDO_ON = 3'b100
  } ldo_state_t;
endpackage
